// >>> core/readout_defines.vh
`ifndef READOUT_DEFINES_VH
`define READOUT_DEFINES_VH

// readout modes
`define MODE_FRAME 2'h0
`define MODE_HFR 2'h1
`define MODE_FOCUS_FAST 2'h2
`define MODE_FOCUS_FASTER 2'h3

// line counts
`define FRAME_FIELD_LINES 12'h0307
`define HFR_LINES 12'h0102
`define HFR_GROUP_ROWS 4'hC
`define HFR_READ_ROWS 4'h4
`define HFR_HSUM 2'h2

// focus mode timing: starts in horizontal periods after vertical sync, skip and spans in lines from the shift
`define FAST_START_H 12'h001A
`define FASTER_START_H 12'h001E
`define FOCUS_SKIP_LINES 12'h0003
`define FAST_SPAN_NTSC 12'h006C
`define FAST_SPAN_PAL 12'h0086
`define FASTER_SPAN 12'h0026

`define PIX_W 12
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// >>> core/line_fifo.v
`timescale 1ns/1ps
`default_nettype none
module line_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire do_wr;
  wire do_rd;
  assign in_ready = (count_reg < DEPTH);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign do_wr = in_valid && in_ready && clk_en;
  assign do_rd = out_valid && out_ready && clk_en;
  always @* begin
    out_data = mem_reg[rd_ptr_reg];
  end
  always @(posedge ref_clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/hcd_adder.v
`timescale 1ns/1ps
`default_nettype none
// sums two vertically read charges per output pixel in the horizontal register
module hcd_adder (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire enable_sum,
  input wire [11:0] pix_in,
  input wire pix_in_valid,
  input wire line_start,
  output reg [11:0] pix_out,
  output reg pix_out_valid
);
  reg [11:0] held_reg;
  reg phase_reg;
  wire [12:0] sum;
  assign sum = {1'b0, held_reg} + {1'b0, pix_in};
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      held_reg <= 12'h000;
      phase_reg <= 1'b0;
      pix_out <= 12'h000;
      pix_out_valid <= 1'b0;
    end else if (clk_en) begin
      pix_out_valid <= 1'b0;
      if (line_start) begin
        phase_reg <= 1'b0;
      end else if (pix_in_valid) begin
        if (!enable_sum) begin
          pix_out <= pix_in;
          pix_out_valid <= 1'b1;
        end else if (!phase_reg) begin
          held_reg <= pix_in;
          phase_reg <= 1'b1;
        end else begin
          // saturate rather than wrap, charge cannot exceed full well
          pix_out <= sum[12] ? 12'hFFF : sum[11:0];
          pix_out_valid <= 1'b1;
          phase_reg <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/ccd_readout_mode_line_select.v
// What this block does
// - frame mode reads every pixel independently, split into two fields in turn
// - frame mode gives 1550 lines: 775 odd then 775 even
// - high rate mode reads 4 of each 12 rows for thirty frames per second
// - high rate mode sums two vertical charges in the horizontal register
// - high rate mode outputs 258 lines per frame
// - focus modes drop top and bottom, outputting only a cut-out band
// - with a sweep in the lead, focus output starts at period 26 (fast) or 30 (faster) after sync
// - window is lines i+3 to i+108/i+134 (fast) or i+38 (faster)
// - window never passes line 258 of the high rate picture
`timescale 1ns/1ps
`default_nettype none
`include "readout_defines.vh"
module ccd_readout_mode_line_select (
  input wire ref_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [1:0] readout_mode,
  input wire pal_select,
  input wire [7:0] frame_shift_lines,
  input wire vertical_sync_pulse,
  input wire horizontal_sync_pulse,
  input wire vertical_transfer_phase_one_a,
  input wire [11:0] pixel_charge,
  input wire pixel_charge_valid,
  output reg [11:0] video_data,
  output wire video_valid,
  input wire video_ready,
  output wire pixel_ready,
  output reg line_valid,
  output reg field_odd,
  output reg [11:0] line_number,
  output reg frame_done
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LEAD = 2'h1;
  localparam ST_ACTIVE = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] mode_reg;
  reg pal_reg;
  reg [7:0] shift_reg;
  reg [11:0] hcount_reg;
  reg [11:0] lines_reg;
  reg [11:0] hfr_row_reg;
  reg [3:0] group_row_reg;
  reg field_reg;
  reg [11:0] out_lines_reg;
  reg swept_reg;

  function [11:0] line_after;
    input [11:0] row;
    begin
      line_after = row + 12'h001;
    end
  endfunction

  function [11:0] line_before;
    input [11:0] row;
    begin
      line_before = row - 12'h001;
    end
  endfunction

  // a row is in the band when its 1-based line lies between the window ends
  function band_hit;
    input [11:0] row;
    input [11:0] first;
    input [11:0] last;
    begin
      band_hit = (line_after(row) >= first) && (line_after(row) <= last);
    end
  endfunction

  // last line index of the selected window, capped at the high rate picture
  function [11:0] window_last;
    input [1:0] mode;
    input pal;
    input [7:0] shift;
    reg [12:0] end_line;
    begin
      end_line = 13'h0000;
      if (mode == `MODE_FOCUS_FAST) begin
        end_line = {5'h00, shift} + {1'b0, (pal ? `FAST_SPAN_PAL : `FAST_SPAN_NTSC)};
      end else begin
        end_line = {5'h00, shift} + {1'b0, `FASTER_SPAN};
      end
      if (end_line > {1'b0, `HFR_LINES}) begin
        window_last = `HFR_LINES;
      end else begin
        window_last = end_line[11:0];
      end
    end
  endfunction

  function [11:0] start_period;
    input [1:0] mode;
    begin
      start_period = (mode == `MODE_FOCUS_FAST) ? `FAST_START_H : `FASTER_START_H;
    end
  endfunction

  wire is_focus;
  wire [11:0] first_line;
  wire [11:0] last_line;
  wire row_read;
  reg line_in_window;
  wire [12:0] first_wide;
  wire [11:0] sum_pix;
  wire sum_valid;
  wire [11:0] sweep_row;

  assign is_focus = mode_reg[1];
  assign first_wide = {5'h00, shift_reg} + {1'b0, `FOCUS_SKIP_LINES};
  // i+1 and i+2 are never emitted, so the consumer never sees them
  assign first_line = first_wide[11:0];
  assign last_line = window_last(mode_reg, pal_reg, shift_reg);
  // 4 of 12 rows are transferred in high rate and focus modes
  assign row_read = (mode_reg == `MODE_FRAME) || (group_row_reg < `HFR_READ_ROWS);
  // rows 1 to i go out with the sweep and rows i+1, i+2 are skipped as spoiled
  assign sweep_row = line_before(first_line);

  always @* begin
    case (mode_reg)
      `MODE_FRAME: line_in_window = 1'b1;
      `MODE_HFR: line_in_window = (hfr_row_reg < `HFR_LINES);
      default: line_in_window = band_hit(hfr_row_reg, first_line, last_line);
    endcase
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (vertical_sync_pulse) begin
          state_next = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (!is_focus || hcount_reg >= line_before(start_period(mode_reg))) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (mode_reg == `MODE_FRAME && lines_reg == `FRAME_FIELD_LINES) begin
          state_next = field_reg ? ST_DONE : ST_IDLE;
        end else if (mode_reg != `MODE_FRAME && hfr_row_reg >= `HFR_LINES) begin
          state_next = ST_DONE;
        end else if (is_focus && hfr_row_reg >= last_line) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      mode_reg <= `MODE_FRAME;
      pal_reg <= 1'b0;
      shift_reg <= 8'h00;
      hcount_reg <= 12'h000;
      lines_reg <= 12'h000;
      hfr_row_reg <= 12'h000;
      group_row_reg <= 4'h0;
      field_reg <= 1'b0;
      line_valid <= 1'b0;
      field_odd <= 1'b1;
      line_number <= 12'h000;
      frame_done <= 1'b0;
      out_lines_reg <= 12'h000;
      swept_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      frame_done <= (state_reg == ST_DONE);
      if (state_reg == ST_IDLE && vertical_sync_pulse) begin
        // settings are latched per frame, but a mode change after the odd frame mode field is taken at the even field's sync
        if (!field_reg || readout_mode != `MODE_FRAME) begin
          mode_reg <= readout_mode;
          pal_reg <= pal_select;
          shift_reg <= frame_shift_lines;
        end
        hcount_reg <= 12'h000;
        lines_reg <= 12'h000;
        hfr_row_reg <= 12'h000;
        group_row_reg <= 4'h0;
        out_lines_reg <= 12'h000;
        line_valid <= 1'b0;
        swept_reg <= 1'b0;
      end else if (horizontal_sync_pulse) begin
        hcount_reg <= hcount_reg + 12'h001;
        line_valid <= 1'b0;
        // a focus frame without a sweep reads the top rows the slow way
        if (state_reg == ST_LEAD && is_focus && vertical_transfer_phase_one_a) begin
          swept_reg <= 1'b1;
        end
        if (state_reg == ST_ACTIVE) begin
          if (row_read) begin
            if (mode_reg == `MODE_FRAME) begin
              lines_reg <= lines_reg + 12'h001;
              line_valid <= 1'b1;
              line_number <= lines_reg + 12'h001;
              field_odd <= ~field_reg;
            end else begin
              hfr_row_reg <= hfr_row_reg + 12'h001;
              if (line_in_window) begin
                line_valid <= 1'b1;
                line_number <= hfr_row_reg + 12'h001;
                out_lines_reg <= out_lines_reg + 12'h001;
                field_odd <= 1'b1;
              end
            end
          end
          if (mode_reg != `MODE_FRAME) begin
            group_row_reg <= (group_row_reg == `HFR_GROUP_ROWS - 4'h1) ? 4'h0 :
                             group_row_reg + 4'h1;
          end
        end
      end
      if (state_reg == ST_LEAD && state_next == ST_ACTIVE && is_focus && swept_reg) begin
        hfr_row_reg <= sweep_row;
      end
      if (state_reg == ST_ACTIVE && mode_reg == `MODE_FRAME &&
          lines_reg == `FRAME_FIELD_LINES) begin
        field_reg <= ~field_reg;
      end
    end
  end

  wire sum_on;
  assign sum_on = (mode_reg != `MODE_FRAME);

  hcd_adder u_adder (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .enable_sum(sum_on),
    .pix_in(pixel_charge),
    .pix_in_valid(pixel_charge_valid && line_valid && pixel_ready),
    .line_start(horizontal_sync_pulse),
    .pix_out(sum_pix),
    .pix_out_valid(sum_valid)
  );

  wire [11:0] fifo_data;
  wire fifo_in_ready;
  // fill_reg mirrors the fifo's count, which the fifo keeps to itself
  reg [4:0] fill_reg;
  reg [4:0] fill_next;
  wire fill_in;
  wire fill_out;
  assign fill_in = sum_valid && fifo_in_ready;
  assign fill_out = video_valid && video_ready;
  // a charge taken now reaches the fifo a cycle later, so refuse it while the
  // word leaving the adder is about to take the last free slot
  assign pixel_ready = fifo_in_ready && !(sum_valid && fill_reg == 5'h0F);

  always @* begin
    fill_next = fill_reg;
    if (fill_in && !fill_out) begin
      fill_next = fill_reg + 5'h01;
    end else if (fill_out && !fill_in) begin
      fill_next = fill_reg - 5'h01;
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      fill_reg <= 5'h00;
    end else if (clk_en) begin
      fill_reg <= fill_next;
    end
  end

  line_fifo #(
    .WIDTH(`PIX_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_data(sum_pix),
    .in_valid(sum_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(video_valid),
    .out_ready(video_ready)
  );

  always @* begin
    video_data = fifo_data;
  end
endmodule
`default_nettype wire


// >>> bench/readout_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module readout_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [1:0] readout_mode,
  input wire logic pal_select,
  input wire logic [7:0] frame_shift_lines,
  input wire logic vertical_sync_pulse,
  input wire logic horizontal_sync_pulse,
  input wire logic [11:0] video_data,
  input wire logic video_valid,
  input wire logic video_ready,
  input wire logic line_valid,
  input wire logic [11:0] line_number,
  input wire logic frame_done
);
  logic [1:0] mode_reg;
  logic pal_reg;
  logic [11:0] lo_reg;
  // mode inputs only count from the sync that latches them
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mode_reg <= 2'h0;
      pal_reg <= 1'b0;
      lo_reg <= 12'h0003;
    end else if (vertical_sync_pulse) begin
      mode_reg <= readout_mode;
      pal_reg <= pal_select;
      lo_reg <= {4'h0, frame_shift_lines} + 12'h0003;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_line_rise;
    !line_valid ##1 line_valid;
  endsequence
  property p_line_answer;
    s_line_rise |-> $past(horizontal_sync_pulse);
  endproperty
  a_line_answer: assert property (p_line_answer) else $error("line without pulse");
  property p_line_stands;
    line_valid && !horizontal_sync_pulse |=> line_valid;
  endproperty
  a_line_stands: assert property (p_line_stands) else $error("line dropped early");
  property p_done_pulse;
    frame_done |=> !frame_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_hfr_cap;
    mode_reg == 2'h1 && line_valid |-> line_number >= 12'h0001 && line_number <= 12'h0102;
  endproperty
  a_hfr_cap: assert property (p_hfr_cap) else $error("high rate line out of range");
  property p_frame_cap;
    mode_reg == 2'h0 && line_valid |-> line_number >= 12'h0001 && line_number <= 12'h0307;
  endproperty
  a_frame_cap: assert property (p_frame_cap) else $error("field line out of range");
  property p_fast_win;
    mode_reg == 2'h2 && line_valid |-> line_number >= lo_reg &&
      line_number <= lo_reg + (pal_reg ? 12'h0083 : 12'h0069);
  endproperty
  a_fast_win: assert property (p_fast_win) else $error("fast window wrong");
  property p_faster_win;
    mode_reg == 2'h3 && line_valid |-> line_number >= lo_reg &&
      line_number <= lo_reg + 12'h0023 && line_number <= 12'h0102;
  endproperty
  a_faster_win: assert property (p_faster_win) else $error("faster window wrong");
  property p_fifo_hold;
    video_valid && !video_ready |=> video_valid && $stable(video_data);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("word lost while stalled");
endmodule
bind ccd_readout_mode_line_select readout_checker u_readout_checker (.ref_clk(ref_clk),
  .reset_n(reset_n), .readout_mode(readout_mode), .pal_select(pal_select),
  .frame_shift_lines(frame_shift_lines), .vertical_sync_pulse(vertical_sync_pulse),
  .horizontal_sync_pulse(horizontal_sync_pulse), .video_data(video_data),
  .video_valid(video_valid), .video_ready(video_ready), .line_valid(line_valid),
  .line_number(line_number), .frame_done(frame_done));
`default_nettype wire

// >>> bench/timing_gen_model.sv
`timescale 1ns/1ps
`default_nettype none
module timing_gen_model (
  input wire logic ref_clk,
  input wire logic start,
  input wire logic sweep_on,
  input wire logic [11:0] h_lines,
  input wire logic [7:0] h_len,
  output logic vertical_sync_pulse,
  output logic horizontal_sync_pulse,
  output logic vertical_transfer_phase_one_a,
  output logic busy
);
  int n;
  initial begin
    vertical_sync_pulse = 1'b0;
    horizontal_sync_pulse = 1'b0;
    vertical_transfer_phase_one_a = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk iff start);
      #1 busy = 1'b1;
      vertical_sync_pulse = 1'b1;
      @(posedge ref_clk);
      #1 vertical_sync_pulse = 1'b0;
      // frame period is set by the line count per mode
      for (n = 1; n <= h_lines; n++) begin
        repeat (h_len - 1) @(posedge ref_clk);
        #1 horizontal_sync_pulse = 1'b1;
        // seven sweep periods (2 to 8), then held low for the rest of the frame
        vertical_transfer_phase_one_a = sweep_on && n >= 2 && n <= 8;
        @(posedge ref_clk);
        #1 horizontal_sync_pulse = 1'b0;
      end
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_ccd_readout_mode_line_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_ccd_readout_mode_line_select;
  logic ref_clk = 0, reset_n = 0, start = 0, pal = 0, pv = 0, vr = 1, sweep_on = 0;
  logic [1:0] mode = 0;
  logic [7:0] shift = 0, h_len = 8'h10;
  logic [11:0] h_lines = 12'h000C, pix = 0, first_num, lines, first_h;
  logic first_odd, hs_d, busy, vs, hs, vt, video_valid, pixel_ready, line_valid, field_odd;
  logic [11:0] video_data, line_number;
  int err_count = 0, check_count = 0, n;
  ccd_readout_mode_line_select u_ccd_readout_mode_line_select (.ref_clk(ref_clk),
    .reset_n(reset_n), .clk_en(1'b1), .readout_mode(mode), .pal_select(pal),
    .frame_shift_lines(shift), .vertical_sync_pulse(vs), .horizontal_sync_pulse(hs),
    .vertical_transfer_phase_one_a(vt), .pixel_charge(pix), .pixel_charge_valid(pv),
    .video_data(video_data), .video_valid(video_valid), .video_ready(vr),
    .pixel_ready(pixel_ready), .line_valid(line_valid), .field_odd(field_odd),
    .line_number(line_number), .frame_done());
  timing_gen_model u_timing_gen_model (.ref_clk(ref_clk), .start(start), .sweep_on(sweep_on),
    .h_lines(h_lines), .h_len(h_len), .vertical_sync_pulse(vs), .horizontal_sync_pulse(hs),
    .vertical_transfer_phase_one_a(vt), .busy(busy));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    hs_d <= hs;
    if (vs) begin
      first_h <= 0;
      lines <= 0;
    end else if (line_valid && hs_d) begin
      lines <= lines + 1;
      if (lines == 0) begin
        first_num <= line_number;
        first_odd <= field_odd;
      end
    end else if (hs && lines == 0) begin
      first_h <= first_h + 1;
    end
  end
  task check(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task frame(input logic [1:0] m, input logic [7:0] s, input logic [11:0] nl, input logic p);
    @(posedge ref_clk);
    #1 mode = m;
    shift = s;
    h_lines = nl;
    pal = p;
    sweep_on = m[1];
    start = 1;
    @(posedge ref_clk);
    #1 start = 0;
    repeat (2) @(posedge ref_clk);
    while (busy) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask
  task t_frame;
    frame(2'h0, 8'h00, 12'h030C, 1'b0);
    check("odd lines", 12'h0307, lines);
    check("odd flag", 12'h0001, {11'h0, first_odd});
    frame(2'h0, 8'h00, 12'h030C, 1'b0);
    check("even lines", 12'h0307, lines);
    check("even flag", 12'h0000, {11'h0, first_odd});
  endtask
  task t_hfr;
    frame(2'h1, 8'h00, 12'h0320, 1'b0);
    check("hfr lines", 12'h0102, lines);
  endtask
  // lines i+1 and i+2 are never expected in the window
  task t_focus;
    frame(2'h2, 8'hA0, 12'h0140, 1'b0);
    check("fast first", 12'h00A3, first_num);
    check("fast count", 12'h0060, lines);
    check("fast start", 12'h001A, first_h);
    frame(2'h2, 8'h00, 12'h01B0, 1'b1);
    check("pal count", 12'h0084, lines);
    frame(2'h3, 8'hFF, 12'h00A0, 1'b0);
    check("faster count", 12'h0001, lines);
    frame(2'h3, 8'h00, 12'h00A0, 1'b0);
    check("faster count", 12'h0024, lines);
    check("faster start", 12'h001E, first_h);
  endtask
  task t_sum;
    h_len = 8'h60;
    @(posedge ref_clk);
    #1 mode = 2'h1;
    h_lines = 12'h0003;
    start = 1;
    @(posedge ref_clk);
    #1 start = 0;
    for (n = 0; n < 200 && !line_valid; n++) begin
      @(posedge ref_clk);
      #1;
    end
    vr = 0;
    for (n = 0; n < 40 && pixel_ready; n++) begin
      pv = 1;
      pix = n[0] ? 12'h0023 : 12'h0100;
      @(posedge ref_clk);
      #1;
    end
    pv = 0;
    check("fifo full", 12'h0000, {11'h0, pixel_ready});
    vr = 1;
    n = 0;
    repeat (40) begin
      if (video_valid === 1'b1) begin
        check("pair sum", 12'h0123, video_data);
        n++;
      end
      @(posedge ref_clk);
      #1;
    end
    check("words", 12'h0001, {11'h0, n == 16 || n == 17});
    while (busy) @(posedge ref_clk);
    h_len = 8'h10;
  endtask
  initial begin
    repeat (70000) @(posedge ref_clk);
    err_count++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1;
    t_frame;
    t_hfr;
    t_focus;
    t_sum;
    conclude;
  end
endmodule
`default_nettype wire
